// *** downstream_port_power_role_ctrl.sv ***
// Downstream port power enable, overcurrent sense and port role swap control.
`timescale 1ns/1ps
`default_nettype none

module downstream_port_power_role_ctrl (
	input wire logic clk,
	input wire logic rst,
	// Per-port enable from configuration or host command, high enables.
	input wire logic [port_power_role_pkg::NUM_PORTS-1:0] port_enable,
	// High selects ganged power control.
	input wire logic ganged_mode,
	// Per-port open-drain pins.
	input wire logic [port_power_role_pkg::NUM_PORTS-1:0] port_power_oc_pin_i,
	output logic [port_power_role_pkg::NUM_PORTS-1:0] port_power_oc_pin_o,
	output logic [port_power_role_pkg::NUM_PORTS-1:0] port_power_oc_pin_oe,
	// Shared open-drain pin used in ganged mode.
	input wire logic ganged_power_pin_i,
	output logic ganged_power_pin_o,
	output logic ganged_power_pin_oe,
	// Role swap request and indicator.
	input wire logic role_swap_select,
	output logic role_swap_indicator,
	// High while port 0 serves as upstream port.
	output logic port0_upstream,
	// High while port 1 serves as upstream port.
	output logic port1_upstream,
	// Overcurrent levels and one-cycle rising-edge events per port.
	output var port_power_role_pkg::oc_status_t oc_status
);

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	// Raw pin levels gathered for the synchroniser bank.
	logic [port_power_role_pkg::SYNC_WIDTH-1:0] raw_inputs;
	// Synchronised copies.
	logic [port_power_role_pkg::SYNC_WIDTH-1:0] synced_inputs;
	// Synchronised per-port pin levels.
	logic [port_power_role_pkg::NUM_PORTS-1:0] port_pin_sync;
	// Synchronised ganged pin level.
	logic gang_pin_sync;
	// Synchronised role select.
	logic role_select_sync;

	assign raw_inputs = {role_swap_select, ganged_power_pin_i, port_power_oc_pin_i};

	// Every sensed pin and the role select pass two flops first.
	sync_bank #(
		.WIDTH(port_power_role_pkg::SYNC_WIDTH),
		.RESET_VALUE(port_power_role_pkg::SYNC_RESET)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.async_in(raw_inputs),
		.sync_out(synced_inputs)
	);

	assign port_pin_sync = synced_inputs[port_power_role_pkg::NUM_PORTS-1:0];
	assign gang_pin_sync = synced_inputs[port_power_role_pkg::SYNC_GANG_POS];
	assign role_select_sync = synced_inputs[port_power_role_pkg::SYNC_ROLE_POS];

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Registered drive for each port pin and for the ganged pin.
	port_power_role_pkg::od_drive_t [port_power_role_pkg::NUM_PORTS-1:0] port_drive_ff;
	port_power_role_pkg::od_drive_t gang_drive_ff;
	// Any port enabled keeps the shared supply on in ganged mode.
	logic any_enabled;

	assign any_enabled = |port_enable;

	// An enabled port releases its pin so the pull-up turns power on;
	// a disabled port drives its pin low. In ganged mode the per-port
	// pins are released and the shared pin carries the control instead.
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int p = 0; p < port_power_role_pkg::NUM_PORTS; p++) begin
				port_drive_ff[p].o <= port_power_role_pkg::PIN_DRIVE_LEVEL;
				port_drive_ff[p].oe <= 1'h1;
			end
			gang_drive_ff.o <= port_power_role_pkg::PIN_DRIVE_LEVEL;
			gang_drive_ff.oe <= 1'h0;
		end else begin
			for (int p = 0; p < port_power_role_pkg::NUM_PORTS; p++) begin
				port_drive_ff[p].o <= port_power_role_pkg::PIN_DRIVE_LEVEL;
				if (ganged_mode) begin
					// Individual pins are idle while the shared pin rules.
					port_drive_ff[p].oe <= 1'h0;
				end else if (port_enable[p]) begin
					// Released: pull-up enables the external switch.
					port_drive_ff[p].oe <= 1'h0;
				end else begin
					// Disabled: drive low to remove port power.
					port_drive_ff[p].oe <= 1'h1;
				end
			end
			gang_drive_ff.o <= port_power_role_pkg::PIN_DRIVE_LEVEL;
			// Shared pin is driven low only when every port is off.
			gang_drive_ff.oe <= ganged_mode && !any_enabled;
		end
	end

	// Unpack registered drive onto the pin ports.
	always_comb begin
		for (int p = 0; p < port_power_role_pkg::NUM_PORTS; p++) begin
			port_power_oc_pin_o[p] = port_drive_ff[p].o;
			port_power_oc_pin_oe[p] = port_drive_ff[p].oe;
		end
	end

	// The board must wire every switch to the shared pin for this to hold.
	assign ganged_power_pin_o = gang_drive_ff.o;
	assign ganged_power_pin_oe = gang_drive_ff.oe;

	// ------------------------------------------------------------
	// Overcurrent sense
	// ------------------------------------------------------------
	// Cycles each pin has been released; saturates at the settle count.
	logic [2:0] settle_ff [port_power_role_pkg::NUM_PORTS];
	// Pin level seen for each port, from its own pin or the shared pin.
	logic [port_power_role_pkg::NUM_PORTS-1:0] sensed_level;
	// Pin currently released by this block, per port.
	logic [port_power_role_pkg::NUM_PORTS-1:0] released;
	// Overcurrent level registers and one-cycle event pulse registers.
	logic [port_power_role_pkg::NUM_PORTS-1:0] oc_level_ff;
	logic [port_power_role_pkg::NUM_PORTS-1:0] oc_event_ff;

	// Choose the sensed pin for a port: the shared pin in ganged mode.
	function automatic logic pick_level(input logic gang, input logic own, input logic shared);
		pick_level = gang ? shared : own;
	endfunction : pick_level

	always_comb begin
		for (int p = 0; p < port_power_role_pkg::NUM_PORTS; p++) begin
			sensed_level[p] = pick_level(ganged_mode, port_pin_sync[p], gang_pin_sync);
			released[p] = port_enable[p] &&
				!(ganged_mode ? gang_drive_ff.oe : port_drive_ff[p].oe);
		end
	end

	// A just-released pin still reads the low we drove through the
	// synchroniser, so it is blanked until the settle count is reached.
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int p = 0; p < port_power_role_pkg::NUM_PORTS; p++) begin
				settle_ff[p] <= 3'h0;
			end
		end else begin
			for (int p = 0; p < port_power_role_pkg::NUM_PORTS; p++) begin
				if (!released[p]) begin
					settle_ff[p] <= 3'h0;
				end else if (settle_ff[p] != port_power_role_pkg::OC_BLANK_CYCLES) begin
					settle_ff[p] <= settle_ff[p] + 3'h1;
				end
			end
		end
	end

	// Low on a settled, enabled pin is overcurrent; an event pulses on
	// the rising edge of that level.
	always_ff @(posedge clk) begin
		if (rst) begin
			oc_level_ff <= '0;
			oc_event_ff <= '0;
		end else begin
			for (int p = 0; p < port_power_role_pkg::NUM_PORTS; p++) begin
				if (released[p] && settle_ff[p] == port_power_role_pkg::OC_BLANK_CYCLES) begin
					oc_level_ff[p] <= !sensed_level[p];
					oc_event_ff[p] <= !sensed_level[p] && !oc_level_ff[p];
				end else begin
					// Disabled or settling ports report no overcurrent.
					oc_level_ff[p] <= 1'h0;
					oc_event_ff[p] <= 1'h0;
				end
			end
		end
	end

	assign oc_status.level = oc_level_ff;
	assign oc_status.event_pulse = oc_event_ff;

	// ------------------------------------------------------------
	// Role swap
	// ------------------------------------------------------------
	// Current role arrangement.
	port_power_role_pkg::role_t role_ff;
	// Role indicator register.
	logic role_ind_ff;

	// The arrangement follows the synchronised select level directly.
	always_ff @(posedge clk) begin
		if (rst) begin
			role_ff <= port_power_role_pkg::ROLE_DEFAULT;
		end else if (role_select_sync) begin
			role_ff <= port_power_role_pkg::ROLE_FLEXED;
		end else begin
			role_ff <= port_power_role_pkg::ROLE_DEFAULT;
		end
	end

	// Indicator is taken from the state in effect, not from the pin,
	// so it never runs ahead of the actual arrangement.
	always_ff @(posedge clk) begin
		if (rst) begin
			role_ind_ff <= port_power_role_pkg::ROLE_IND_RESET;
		end else begin
			unique case (role_ff)
				port_power_role_pkg::ROLE_DEFAULT: begin
					role_ind_ff <= 1'h0;
				end
				port_power_role_pkg::ROLE_FLEXED: begin
					role_ind_ff <= 1'h1;
				end
				default: begin
					role_ind_ff <= port_power_role_pkg::ROLE_IND_RESET;
				end
			endcase
		end
	end

	assign role_swap_indicator = role_ind_ff;
	// Port roles decoded from the state in effect.
	assign port0_upstream = (role_ff == port_power_role_pkg::ROLE_DEFAULT);
	assign port1_upstream = (role_ff == port_power_role_pkg::ROLE_FLEXED);

endmodule : downstream_port_power_role_ctrl

`default_nettype wire

// *** port_power_role_pkg.sv ***
// Shared constants and types for downstream port power and role control.
package port_power_role_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	// Number of downstream power/overcurrent pins.
	localparam int unsigned NUM_PORTS = 6;
	// Width of the synchroniser bank: six port pins, ganged pin, role select.
	localparam int unsigned SYNC_WIDTH = 8;
	// Bit position of the ganged pin inside the synchroniser bank.
	localparam int unsigned SYNC_GANG_POS = 6;
	// Bit position of the role select inside the synchroniser bank.
	localparam int unsigned SYNC_ROLE_POS = 7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	// Pins idle high under their pull-ups, role select idles low.
	localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 8'h7F;
	// Role indicator after reset shows the default arrangement.
	localparam logic ROLE_IND_RESET = 1'h0;
	// Level that the driven pin and its data output take.
	localparam logic PIN_DRIVE_LEVEL = 1'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	// Clock period in nanoseconds.
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Settle time after a pin is released before its level is trusted.
	localparam int unsigned OC_BLANK_NS = 30;
	// Settle time in cycles, rounded up; three cycles for 30 ns.
	localparam int unsigned OC_BLANK_CYCLES_INT =
		(OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] OC_BLANK_CYCLES = 3'(OC_BLANK_CYCLES_INT);

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	// Port role arrangement, one-hot.
	typedef enum logic [1:0] {
		ROLE_DEFAULT = 2'h1,
		ROLE_FLEXED = 2'h2
	} role_t;

	// Drive level and output enable of one open-drain pin.
	typedef struct packed {
		logic o;
		logic oe;
	} od_drive_t;

	// Overcurrent status of the downstream ports.
	typedef struct packed {
		logic [NUM_PORTS-1:0] level;
		logic [NUM_PORTS-1:0] event_pulse;
	} oc_status_t;

endpackage : port_power_role_pkg

// *** sync_bank.sv ***
// Two-stage synchroniser bank with a constant reset value.
`timescale 1ns/1ps
`default_nettype none

module sync_bank #(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------
	// First stage is read only by the second stage.
	logic [WIDTH-1:0] meta_ff;
	// Second stage feeds the rest of the block.
	logic [WIDTH-1:0] sync_ff;

	// Both stages reset to a constant so no pin value leaks into reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= RESET_VALUE;
			sync_ff <= RESET_VALUE;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule : sync_bank

`default_nettype wire

// *** port_power_role_checker.sv ***
// Assertion checker for downstream port power and role control.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Checker
// ----------------------------------------
module port_power_role_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [5:0] port_enable,
	input wire logic ganged_mode,
	input wire logic [5:0] port_power_oc_pin_i,
	input wire logic [5:0] port_power_oc_pin_o,
	input wire logic [5:0] port_power_oc_pin_oe,
	input wire logic ganged_power_pin_i,
	input wire logic ganged_power_pin_oe,
	input wire logic role_swap_select,
	input wire logic role_swap_indicator,
	input wire logic port0_upstream,
	input wire logic port1_upstream,
	input wire port_power_role_pkg::oc_status_t oc_status
);
	// All checks share the core clock and its reset.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_release;
		!ganged_mode |=> (port_power_oc_pin_oe & $past(port_enable)) == 6'h00;
	endproperty
	a_release: assert property (p_release) else $error("enabled pin driven");
	property p_drive;
		!ganged_mode |=> (port_power_oc_pin_oe | $past(port_enable)) == 6'h3F
			&& port_power_oc_pin_o == 6'h00;
	endproperty
	a_drive: assert property (p_drive) else $error("disabled pin not low");
	property p_gang;
		ganged_mode |=> port_power_oc_pin_oe == 6'h00
			&& ganged_power_pin_oe == ($past(port_enable) == 6'h00);
	endproperty
	a_gang: assert property (p_gang) else $error("ganged pin drive wrong");
	// Eight cycles cover the two flops, the settle time and the register.
	property p_oc_set;
		(!ganged_mode && port_enable[0] && !port_power_oc_pin_i[0]) [*8]
			|-> oc_status.level[0];
	endproperty
	a_oc_set: assert property (p_oc_set) else $error("overcurrent missed");
	property p_oc_clr;
		(!ganged_mode && port_power_oc_pin_i[0]) [*5] |-> !oc_status.level[0];
	endproperty
	a_oc_clr: assert property (p_oc_clr) else $error("false overcurrent");
	property p_event;
		$rose(oc_status.level[0]) |-> oc_status.event_pulse[0] ##1 !oc_status.event_pulse[0];
	endproperty
	a_event: assert property (p_event) else $error("event pulse wrong");
	property p_role_def;
		!role_swap_select [*4] |-> port0_upstream && !port1_upstream;
	endproperty
	a_role_def: assert property (p_role_def) else $error("default roles wrong");
	property p_role_flex;
		role_swap_select [*4] |-> port1_upstream && !port0_upstream;
	endproperty
	a_role_flex: assert property (p_role_flex) else $error("flexed roles wrong");
	property p_ind;
		$stable(role_swap_select) [*5] |-> role_swap_indicator == role_swap_select;
	endproperty
	a_ind: assert property (p_ind) else $error("indicator wrong");
	property p_sync;
		!role_swap_select [*4] ##1 role_swap_select |=> port0_upstream [*2];
	endproperty
	a_sync: assert property (p_sync) else $error("select not synchronised");
endmodule : port_power_role_checker

bind downstream_port_power_role_ctrl port_power_role_checker u_chk (
	.clk(clk), .rst(rst), .port_enable(port_enable), .ganged_mode(ganged_mode),
	.port_power_oc_pin_i(port_power_oc_pin_i), .port_power_oc_pin_o(port_power_oc_pin_o),
	.port_power_oc_pin_oe(port_power_oc_pin_oe), .ganged_power_pin_i(ganged_power_pin_i),
	.ganged_power_pin_oe(ganged_power_pin_oe), .role_swap_select(role_swap_select),
	.role_swap_indicator(role_swap_indicator), .port0_upstream(port0_upstream),
	.port1_upstream(port1_upstream), .oc_status(oc_status));
`default_nettype wire

// *** port_power_partner.sv ***
// Model of the external power switches and current monitors.
`timescale 1ns/1ps
`default_nettype none

module port_power_partner (
	input wire logic ganged_mode,
	input wire logic [5:0] pin_oe,
	input wire logic gang_oe,
	input wire logic [5:0] fault,
	input wire logic gang_fault,
	output logic [5:0] pin_level,
	output logic gang_level
);
	// A released pin sits at its pull-up; a monitor in fault pulls it low.
	// In ganged mode the monitors hang off the shared pin only.
	assign pin_level = ganged_mode ? ~pin_oe : ~pin_oe & ~fault;
	assign gang_level = !gang_oe && !gang_fault;
endmodule : port_power_partner
`default_nettype wire

// *** downstream_port_power_role_ctrl_test.sv ***
// Self-checking testbench for downstream port power and role control.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("wrong value %s expected %h seen %h", nm, exp, got); \
		end \
	end

module downstream_port_power_role_ctrl_test;
	logic clk, rst, gm, sel, ind, up0, up1, gang_i, gang_o, gang_oe, gf;
	logic [5:0] en, pin_i, pin_o, pin_oe, fault;
	port_power_role_pkg::oc_status_t oc;
	int errors = 0;
	int tests_run = 0;
	int events = 0; // Event pulses seen.

	downstream_port_power_role_ctrl DUT (.clk(clk), .rst(rst), .port_enable(en),
		.ganged_mode(gm), .port_power_oc_pin_i(pin_i), .port_power_oc_pin_o(pin_o),
		.port_power_oc_pin_oe(pin_oe), .ganged_power_pin_i(gang_i),
		.ganged_power_pin_o(gang_o), .ganged_power_pin_oe(gang_oe),
		.role_swap_select(sel), .role_swap_indicator(ind), .port0_upstream(up0),
		.port1_upstream(up1), .oc_status(oc));
	port_power_partner u_far (.ganged_mode(gm), .pin_oe(pin_oe), .gang_oe(gang_oe),
		.fault(fault), .gang_fault(gf), .pin_level(pin_i), .gang_level(gang_i));

	// ----------------------------------------
	// Clock, event count and tasks
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		events <= events + $countones(oc.event_pulse);
	end
	// Inputs change at the falling edge, away from the sampling edge.
	task automatic drive(input logic [5:0] e, input logic g, input logic [5:0] f,
		input logic x, input logic s);
		@(negedge clk);
		en = e;
		gm = g;
		fault = f;
		gf = x;
		sel = s;
	endtask : drive
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize

	// A hang is cut short well beyond the roughly 150 cycles of the run.
	initial begin
		#50000;
		errors++;
		summarize();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{en, gm, fault, gf, sel} = '0;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		drive(6'h00, 0, 6'h00, 0, 0);
		idle(2);
		`CHECK("pin drive", 6'h3F, pin_oe)
		`CHECK("pin level", 6'h00, pin_o)
		`CHECK("upstream 0", 1'b1, up0)
		`CHECK("upstream 1", 1'b0, up1)
		$display("test reset done");
		drive(6'h3F, 0, 6'h00, 0, 0);
		idle(1);
		`CHECK("pin drive", 6'h00, pin_oe)
		drive(6'h3B, 0, 6'h00, 0, 0);
		idle(1);
		`CHECK("pin drive", 6'h04, pin_oe)
		$display("test enable done");
		for (int p = 0; p < 6; p++) begin
			drive(6'h3F, 0, 6'h01 << p, 0, 0);
			idle(8);
			`CHECK("oc level", 6'h01 << p, oc.level)
			drive(6'h3F, 0, 6'h00, 0, 0);
			idle(5);
			`CHECK("oc level", 6'h00, oc.level)
		end
		`CHECK("oc events", 6, events)
		// A disabled port pulls its own pin low, which is no overcurrent.
		drive(6'h3E, 0, 6'h01, 0, 0);
		idle(8);
		`CHECK("oc level", 6'h00, oc.level)
		$display("test overcurrent done");
		drive(6'h3F, 1, 6'h00, 1, 0);
		idle(8);
		`CHECK("pin drive", 6'h00, pin_oe)
		`CHECK("oc level", 6'h3F, oc.level)
		drive(6'h00, 1, 6'h00, 0, 0);
		idle(2);
		`CHECK("gang drive", 1'b1, gang_oe)
		`CHECK("gang level", 1'b0, gang_o)
		$display("test ganged done");
		drive(6'h00, 0, 6'h00, 0, 1);
		idle(2);
		`CHECK("upstream 0", 1'b1, up0)
		idle(1);
		`CHECK("upstream 1", 1'b1, up1)
		`CHECK("upstream 0", 1'b0, up0)
		idle(1);
		`CHECK("indicator", 1'b1, ind)
		drive(6'h00, 0, 6'h00, 0, 0);
		idle(4);
		`CHECK("upstream 0", 1'b1, up0)
		`CHECK("upstream 1", 1'b0, up1)
		`CHECK("indicator", 1'b0, ind)
		$display("test role done");
		summarize();
	end
endmodule : downstream_port_power_role_ctrl_test
`default_nettype wire
